// >>> rtl/mid_core.sv
// instruction decode and execute core for 13-bit program words
`timescale 1ns/1ps
`default_nettype none
module mid_core
    import mid_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH // return stack depth
) (
    input wire logic clock_in, // oscillator clock
    input wire logic arst_n_in, // asynchronous reset, active low
    input wire logic cycle_length_option_in, // 1 = four periods per cycle
    input wire logic [12:0] rom_data_in, // word at rom_addr_out
    output logic [12:0] rom_addr_out, // fetch address
    output logic [7:0] acc_out, // accumulator
    output logic [7:0] status_out, // status register
    output logic [7:0] bank_out, // bank select register
    output logic [7:0] cont_out, // control register
    output logic irq_enable_out, // interrupt enable
    output logic sleep_out, // oscillator stopped
    output logic wdt_clear_out, // watchdog clear pulse
    output logic instr_done_out // pulse at each executed cycle
);
    localparam int SP_W = $clog2(DEPTH);

    logic [1:0] phase_reg; // oscillator period within the cycle
    logic cycle_opt_reg; // option held for the whole cycle
    logic [12:0] pc_reg; // program counter
    logic [12:0] pc_next;
    logic [12:0] pc_plus; // address of the following word
    logic [12:0] stack_mem [DEPTH]; // return addresses
    logic [SP_W-1:0] sp_reg; // next free stack slot
    logic [7:0] acc_reg;
    logic [7:0] status_reg;
    logic [7:0] bank_reg;
    logic [7:0] cont_reg;
    logic [7:0] file_mem [64]; // general and i/o registers
    logic irq_en_reg;
    logic sleep_reg;
    logic wdt_clr_reg;
    logic done_reg;
    logic skip_reg; // next word is discarded
    logic long_pend_reg; // next word is a long target
    logic long_call_reg; // pending long op pushes
    logic exec; // last period of a running cycle
    logic normal; // word is a real instruction

    // decoded controls
    mid_alu_e alu_op;
    logic use_lit; // literal replaces the register operand
    logic to_acc;
    logic to_reg;
    logic upd_z;
    logic upd_c;
    logic upd_dc;
    logic skip_zero;
    logic skip_bit;
    logic skip_val;
    logic do_call;
    logic do_jmp;
    logic do_ret;
    logic do_long;
    logic do_bank;
    logic do_sleep;
    logic do_watchdog_clear_op;
    logic [7:0] rval; // register operand value
    logic [7:0] res;
    logic alu_c;
    logic alu_dc;
    logic skip_now;

    wire logic [5:0] raddr = rom_data_in[5:0]; // register operand
    wire logic [2:0] bsel = rom_data_in[8:6];

    // reads bank, pc low byte and status from their own state, others from the file
    function automatic logic [7:0] read_reg(input logic [5:0] a);
        logic [7:0] v;
        v = file_mem[a];
        if (a == ADDR_BANK) begin
            v = bank_reg;
        end else if (a == ADDR_PC) begin
            v = pc_reg[7:0];
        end else if (a == ADDR_STATUS) begin
            v = status_reg;
        end
        return v;
    endfunction : read_reg

    assign rval = read_reg(raddr); // i/o and general alike
    assign exec = ~sleep_reg && (phase_reg == (cycle_opt_reg ? LAST_PHASE_4 : LAST_PHASE_2));
    assign normal = ~skip_reg && ~long_pend_reg;
    assign pc_plus = pc_reg + 13'h0001;

    // period counter; the fetched word has settled before the last period
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            phase_reg <= 2'h0;
        end else if (exec) begin
            phase_reg <= 2'h0;
        end else if (!sleep_reg) begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    // option only changes at a cycle boundary so no cycle is torn
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cycle_opt_reg <= CYCLE_OPT_RST; // four periods by default
        end else if (exec) begin
            cycle_opt_reg <= cycle_length_option_in;
        end
    end

    // decode of the whole 13-bit word
    always_comb begin
        alu_op = MID_PASS_R;
        use_lit = 1'b0;
        to_acc = 1'b0;
        to_reg = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        upd_dc = 1'b0;
        skip_zero = 1'b0;
        skip_bit = 1'b0;
        skip_val = 1'b0;
        do_call = 1'b0;
        do_jmp = 1'b0;
        do_ret = 1'b0;
        do_long = 1'b0;
        do_bank = 1'b0;
        do_sleep = 1'b0;
        do_watchdog_clear_op = 1'b0;
        if (rom_data_in[12]) begin
            // literal group: 8-bit data, 10-bit targets
            use_lit = 1'b1;
            to_acc = 1'b1;
            case (rom_data_in[11:8])
                4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
                    to_acc = 1'b0;
                    do_call = ~rom_data_in[10];
                    do_jmp = rom_data_in[10];
                end
                4'h8: alu_op = MID_PASS_R;
                4'h9: begin alu_op = MID_OR; upd_z = 1'b1; end
                4'hA: begin alu_op = MID_AND; upd_z = 1'b1; end
                4'hB: begin alu_op = MID_XOR; upd_z = 1'b1; end
                4'hC: do_ret = 1'b1; // literal to acc, pop
                4'hD: begin
                    alu_op = MID_SUB;
                    {upd_z, upd_c, upd_dc} = 3'b111;
                end
                4'hE: begin
                    to_acc = 1'b0;
                    do_bank = rom_data_in[7:4] == EXT_BANK;
                    do_long = rom_data_in[7:4] == EXT_FAR_CALL ||
                              rom_data_in[7:4] == EXT_FAR_JUMP;
                end
                4'hF: begin
                    alu_op = MID_ADD;
                    {upd_z, upd_c, upd_dc} = 3'b111;
                end
                default: to_acc = 1'b0;
            endcase
        end else if (rom_data_in[11]) begin
            // bit group
            case (rom_data_in[12:9])
                GRP_BCLR: begin alu_op = MID_BCLR; to_reg = 1'b1; end
                GRP_BSET: begin alu_op = MID_BSET; to_reg = 1'b1; end
                GRP_JBC: skip_bit = 1'b1;
                default: begin skip_bit = 1'b1; skip_val = 1'b1; end
            endcase
        end else begin
            // register group; bit 6 picks register or accumulator target
            to_reg = rom_data_in[6];
            to_acc = ~rom_data_in[6];
            upd_z = 1'b1;
            case (rom_data_in[10:7])
                4'h0: begin
                    to_acc = 1'b0;
                    upd_z = 1'b0;
                    alu_op = MID_PASS_A; // mov register from accumulator
                    if (!rom_data_in[6]) begin
                        to_reg = 1'b0;
                        do_sleep = rom_data_in == OP_SLEEP;
                        do_watchdog_clear_op = rom_data_in == OP_WDOG_CLR;
                        do_ret = rom_data_in == OP_RET || rom_data_in == OP_RETI;
                        to_acc = rom_data_in == OP_DAA || rom_data_in == OP_CONTR;
                        upd_c = rom_data_in == OP_DAA;
                        alu_op = rom_data_in == OP_DAA ? MID_DAA : MID_PASS_R;
                    end
                end
                4'h1: alu_op = MID_ZERO;
                4'h2: begin alu_op = MID_SUB; {upd_c, upd_dc} = 2'b11; end
                4'h3: alu_op = MID_DEC;
                4'h4: alu_op = MID_OR;
                4'h5: alu_op = MID_AND;
                4'h6: alu_op = MID_XOR;
                4'h7: begin alu_op = MID_ADD; {upd_c, upd_dc} = 2'b11; end
                4'h8: alu_op = MID_PASS_R;
                4'h9: alu_op = MID_COM;
                4'hA: alu_op = MID_INC;
                4'hB: begin alu_op = MID_DEC; upd_z = 1'b0; skip_zero = 1'b1; end
                4'hC: begin alu_op = MID_ROR; upd_z = 1'b0; upd_c = 1'b1; end
                4'hD: begin alu_op = MID_ROL; upd_z = 1'b0; upd_c = 1'b1; end
                4'hE: begin alu_op = MID_SWAP; upd_z = 1'b0; end
                default: begin alu_op = MID_INC; upd_z = 1'b0; skip_zero = 1'b1; end
            endcase
        end
    end

    mid_alu u_alu (
        .op_in(alu_op),
        .acc_in(acc_reg),
        .opnd_in(use_lit ? rom_data_in[7:0] : rval),
        .bit_in(bsel),
        .carry_in(status_reg[ST_C]),
        .res_out(res),
        .carry_out(alu_c),
        .dc_out(alu_dc)
    );

    // skip on a zero result or on the tested bit
    assign skip_now = normal && ((skip_zero && res == BYTE_ZERO) ||
                                 (skip_bit && rval[bsel] == skip_val));

    // next program counter; a write to its low byte is just another target
    always_comb begin
        pc_next = pc_plus;
        if (long_pend_reg) begin
            pc_next = rom_data_in; // full 13-bit target
        end else if (!normal) begin
            pc_next = pc_plus; // discarded word
        end else if (to_reg && raddr == ADDR_PC) begin
            pc_next = {pc_reg[12:8], res}; // still one cycle
        end else if (do_call || do_jmp) begin
            pc_next = {pc_reg[12:10], rom_data_in[9:0]};
        end else if (do_ret) begin
            pc_next = stack_mem[sp_reg - SP_W'(1)];
        end
    end

    // program counter and return stack; the stack wraps when overfilled
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pc_reg <= 13'h0000;
            sp_reg <= '0;
        end else if (exec) begin
            pc_reg <= pc_next;
            if ((normal && do_call) || (long_pend_reg && long_call_reg)) begin
                stack_mem[sp_reg] <= pc_plus;
                sp_reg <= sp_reg + SP_W'(1);
            end else if (normal && do_ret) begin
                sp_reg <= sp_reg - SP_W'(1);
            end
        end
    end

    // skip and long-target sequencing
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            skip_reg <= 1'b0;
            long_pend_reg <= 1'b0;
            long_call_reg <= 1'b0;
        end else if (exec) begin
            skip_reg <= skip_now;
            long_pend_reg <= normal && do_long;
            long_call_reg <= rom_data_in[7:4] == EXT_FAR_CALL;
        end
    end

    // accumulator
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            acc_reg <= BYTE_ZERO;
        end else if (exec && normal && to_acc) begin
            acc_reg <= rom_data_in == OP_CONTR ? cont_reg : res;
        end
    end

    // register file; the program counter byte lives in its own register
    always_ff @(posedge clock_in) begin
        if (exec && normal && to_reg && raddr > ADDR_STATUS) begin
            file_mem[raddr] <= res;
        end
    end

    // status: a direct write lands first, flag results then win
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            status_reg <= STATUS_RST;
        end else if (exec && normal) begin
            if (to_reg && raddr == ADDR_STATUS) begin
                status_reg <= res;
            end
            if (upd_z) begin
                status_reg[ST_Z] <= res == BYTE_ZERO;
            end
            if (upd_c) begin
                status_reg[ST_C] <= alu_c;
            end
            if (upd_dc) begin
                status_reg[ST_DC] <= alu_dc;
            end
            if (do_sleep || do_watchdog_clear_op) begin
                status_reg[ST_T] <= 1'b1;
                status_reg[ST_P] <= do_watchdog_clear_op;
            end
        end
    end

    // bank, control, interrupt enable
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bank_reg <= BYTE_ZERO;
            cont_reg <= BYTE_ZERO;
            irq_en_reg <= 1'b0;
        end else if (exec && normal) begin
            if (do_bank) begin
                bank_reg[1:0] <= rom_data_in[1:0];
            end else if (to_reg && raddr == ADDR_BANK) begin
                bank_reg <= res;
            end
            if (rom_data_in == OP_CONTW) begin
                cont_reg <= acc_reg;
            end
            if (rom_data_in == OP_ENI || rom_data_in == OP_RETI) begin
                irq_en_reg <= 1'b1;
            end else if (rom_data_in == OP_DISI) begin
                irq_en_reg <= 1'b0;
            end
        end
    end

    // sleep stops the cycle until reset; both ops clear the watchdog
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sleep_reg <= 1'b0;
            wdt_clr_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            wdt_clr_reg <= exec && normal && (do_sleep || do_watchdog_clear_op);
            done_reg <= exec;
            if (exec && normal && do_sleep) begin
                sleep_reg <= 1'b1;
            end
        end
    end

    assign rom_addr_out = pc_reg;
    assign acc_out = acc_reg;
    assign status_out = status_reg;
    assign bank_out = bank_reg;
    assign cont_out = cont_reg;
    assign irq_enable_out = irq_en_reg;
    assign sleep_out = sleep_reg;
    assign wdt_clear_out = wdt_clr_reg;
    assign instr_done_out = done_reg;
endmodule : mid_core
`default_nettype wire

// >>> rtl/mid_pkg.sv
// shared constants and types for the instruction decode and execute core
package mid_pkg;
    // word widths
    localparam int INSTR_W = 13; // one instruction word
    localparam int DATA_W = 8; // data path and file registers
    localparam int PC_W = 13; // program counter
    localparam int RADDR_W = 6; // register operand field
    localparam int STACK_DEPTH = 8; // return stack entries
    localparam int SHORT_W = 10; // short call and jump literal

    // special register addresses
    localparam logic [5:0] ADDR_BANK = 6'h01; // bank select register
    localparam logic [5:0] ADDR_PC = 6'h02; // program counter low byte
    localparam logic [5:0] ADDR_STATUS = 6'h03; // status register
    localparam logic [5:0] ADDR_IRQ_FLAG = 6'h0F; // interrupt flag register

    // status bit positions and reset value
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_P = 3;
    localparam int ST_T = 4;
    localparam logic [7:0] STATUS_RST = 8'h18; // timeout and power-down flags high
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // cycle length option: 1 selects four oscillator periods
    localparam logic CYCLE_OPT_RST = 1'b1;
    localparam logic [1:0] LAST_PHASE_2 = 2'h1; // two periods per cycle
    localparam logic [1:0] LAST_PHASE_4 = 2'h3; // four periods per cycle

    // fixed opcodes
    localparam logic [12:0] OP_DAA = 13'h0001;
    localparam logic [12:0] OP_CONTW = 13'h0002;
    localparam logic [12:0] OP_SLEEP = 13'h0003;
    localparam logic [12:0] OP_WDOG_CLR = 13'h0004;
    localparam logic [12:0] OP_ENI = 13'h0010;
    localparam logic [12:0] OP_DISI = 13'h0011;
    localparam logic [12:0] OP_RET = 13'h0012;
    localparam logic [12:0] OP_RETI = 13'h0013;
    localparam logic [12:0] OP_CONTR = 13'h0014;

    // bit operation group in bits 12..9
    localparam logic [3:0] GRP_BCLR = 4'h4;
    localparam logic [3:0] GRP_BSET = 4'h5;
    localparam logic [3:0] GRP_JBC = 4'h6;
    localparam logic [3:0] GRP_JBS = 4'h7;
    // extended literal sub-codes in bits 7..4
    localparam logic [3:0] EXT_BANK = 4'h9;
    localparam logic [3:0] EXT_FAR_CALL = 4'hA;
    localparam logic [3:0] EXT_FAR_JUMP = 4'hB;

    // arithmetic and logic operations; four-state base so it can ride on a net port
    typedef enum logic [4:0] {
        MID_PASS_R, MID_PASS_A, MID_ZERO, MID_SUB, MID_DEC, MID_INC,
        MID_OR, MID_AND, MID_XOR, MID_ADD, MID_COM, MID_ROR, MID_ROL,
        MID_SWAP, MID_BCLR, MID_BSET, MID_DAA
    } mid_alu_e;
endpackage : mid_pkg

// >>> rtl/mid_alu.sv
// arithmetic and logic unit of the decode and execute core
`timescale 1ns/1ps
`default_nettype none
module mid_alu
    import mid_pkg::*;
(
    input wire mid_alu_e op_in, // operation select
    input wire logic [7:0] acc_in, // accumulator operand
    input wire logic [7:0] opnd_in, // register or literal operand
    input wire logic [2:0] bit_in, // bit index for bit operations
    input wire logic carry_in, // current carry flag
    output logic [7:0] res_out, // result byte
    output logic carry_out, // new carry
    output logic dc_out // new digit carry
);
    logic [8:0] wide; // nine-bit sum keeps the carry
    logic [4:0] low; // nibble sum keeps the digit carry
    logic [7:0] mask; // one-hot bit mask

    // purely combinational; flags are only used where the decoder asks
    always_comb begin
        wide = 9'h000;
        low = 5'h00;
        mask = 8'h01 << bit_in;
        res_out = opnd_in;
        carry_out = carry_in;
        dc_out = 1'b0;
        case (op_in)
            MID_PASS_A: res_out = acc_in;
            MID_ZERO: res_out = BYTE_ZERO;
            MID_SUB: begin
                // carry high means no borrow
                wide = {1'b0, opnd_in} - {1'b0, acc_in};
                low = {1'b0, opnd_in[3:0]} - {1'b0, acc_in[3:0]};
                res_out = wide[7:0];
                carry_out = ~wide[8];
                dc_out = ~low[4];
            end
            MID_ADD: begin
                wide = {1'b0, opnd_in} + {1'b0, acc_in};
                low = {1'b0, opnd_in[3:0]} + {1'b0, acc_in[3:0]};
                res_out = wide[7:0];
                carry_out = wide[8];
                dc_out = low[4];
            end
            MID_DEC: res_out = opnd_in - 8'h01;
            MID_INC: res_out = opnd_in + 8'h01;
            MID_OR: res_out = opnd_in | acc_in;
            MID_AND: res_out = opnd_in & acc_in;
            MID_XOR: res_out = opnd_in ^ acc_in;
            MID_COM: res_out = ~opnd_in;
            MID_ROR: begin
                // bit 0 leaves through carry, old carry enters bit 7
                res_out = {carry_in, opnd_in[7:1]};
                carry_out = opnd_in[0];
            end
            MID_ROL: begin
                // bit 7 leaves through carry, old carry enters bit 0
                res_out = {opnd_in[6:0], carry_in};
                carry_out = opnd_in[7];
            end
            MID_SWAP: res_out = {opnd_in[3:0], opnd_in[7:4]};
            MID_BCLR: res_out = opnd_in & ~mask;
            MID_BSET: res_out = opnd_in | mask;
            MID_DAA: begin
                // decimal adjust of the accumulator
                wide = {1'b0, acc_in};
                if (wide[3:0] > 4'h9) begin
                    wide = wide + 9'h006;
                end
                if (carry_in || wide[8:4] > 5'h09) begin
                    wide = wide + 9'h060;
                end
                res_out = wide[7:0];
                carry_out = carry_in | wide[8];
            end
            default: res_out = opnd_in;
        endcase
    end
endmodule : mid_alu
`default_nettype wire

// >>> tb/mid_core_props.sv
// port-level assertion checker for the decode and execute core
`timescale 1ns/1ps
`default_nettype none
module mid_core_props
    import mid_pkg::*;
(
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic [12:0] rom_addr_out,
    input wire logic [7:0] acc_out,
    input wire logic [7:0] status_out,
    input wire logic sleep_out,
    input wire logic wdt_clear_out,
    input wire logic instr_done_out
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!arst_n_in);

    a_done_one_pulse: assert property (instr_done_out |=> !instr_done_out)
        else $error("done pulse wider than one clock");
    // state only moves on the executing edge, which done follows at once
    a_pc_moves_exec: assert property ($changed(rom_addr_out) |-> instr_done_out)
        else $error("fetch address moved outside an executing edge");
    a_acc_moves_exec: assert property ($changed(acc_out) |-> instr_done_out)
        else $error("accumulator moved outside an executing edge");
    a_wdt_with_done: assert property (wdt_clear_out |-> instr_done_out)
        else $error("watchdog clear without an executed instruction");
    a_wdt_sets_flag: assert property ($rose(wdt_clear_out) |-> status_out[ST_T])
        else $error("timeout flag low after watchdog clear");
    a_sleep_sticky: assert property (sleep_out |=> sleep_out)
        else $error("sleep left without reset");
    // a stopped oscillator means nothing is fetched or executed any more
    a_sleep_freeze: assert property (sleep_out [*2] |-> $stable(rom_addr_out))
        else $error("fetch address moved while asleep");
    a_sleep_no_done: assert property (sleep_out [*2] |-> !instr_done_out)
        else $error("instruction executed while asleep");
endmodule : mid_core_props
`default_nettype wire

// >>> tb/mid_rom_model.sv
// program rom model feeding 13-bit words to the core
`timescale 1ns/1ps
`default_nettype none
module mid_rom_model (
    input wire logic [12:0] addr_in, // fetch address
    output logic [12:0] data_out // word at that address
);
    logic [12:0] mem [0:127] = '{default: 13'h0000}; // unwritten words act as no-operation
    // combinational read; each fetch hands over one whole word
    assign data_out = (addr_in < 13'd128) ? mem[addr_in[6:0]] : 13'h0000;
endmodule : mid_rom_model
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench: runs one program in both cycle lengths
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mid_pkg::*;
    logic clock_in = 1'b0; // 100 MHz core clock
    logic arst_n_in = 1'b0; // reset, active low
    logic opt = 1'b1; // cycle length option
    logic [12:0] addr, data;
    logic [7:0] acc, st, bank, cont;
    logic sleep, wdt, done, irq;
    logic [7:0] e_acc[$]; // expected accumulator per step
    logic [12:0] e_pc[$]; // expected address, 1fff means not checked
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0;
    always #5 clock_in = ~clock_in;
    mid_rom_model mid_rom_model_inst (.addr_in(addr), .data_out(data));
    mid_core mid_core_inst (.clock_in(clock_in), .arst_n_in(arst_n_in),
        .cycle_length_option_in(opt), .rom_data_in(data), .rom_addr_out(addr),
        .acc_out(acc), .status_out(st), .bank_out(bank), .cont_out(cont),
        .irq_enable_out(irq), .sleep_out(sleep), .wdt_clear_out(wdt), .instr_done_out(done));
    // bench-side expectations for the rotate results
    function automatic logic [7:0] ror_f(logic [7:0] v, logic c);
        return {c, v[7:1]};
    endfunction : ror_f
    function automatic logic [7:0] rol_f(logic [7:0] v, logic c);
        return {v[6:0], c};
    endfunction : rol_f
    task automatic check(string what, logic [12:0] seen, logic [12:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    task automatic put(int a, logic [12:0] w, logic [7:0] ea, logic [12:0] ep);
        mid_rom_model_inst.mem[a] = w;
        e_acc.push_back(ea);
        e_pc.push_back(ep);
    endtask : put
    // program never touches bits of the interrupt flag register
    task automatic run(logic mode);
        logic [7:0] k, k2, k3;
        logic [1:0] b;
        int gap;
        k = 8'($urandom);
        k2 = 8'($urandom);
        k3 = 8'($urandom);
        b = 2'($urandom);
        e_acc.delete();
        e_pc.delete();
        put(0, {5'h18, k}, k, 1);
        put(1, 13'h0050, k, 2);
        put(2, 13'h0610, ror_f(k, 1'b0), 3);
        put(3, 13'h0690, rol_f(k, k[0]), 4);
        put(4, 13'h0710, {k[3:0], k[7:4]}, 5);
        put(5, 13'h1801, 8'h01, 6);
        put(6, 13'h0050, 8'h01, 7);
        put(7, 13'h05D0, 8'h01, 8);
        put(8, 13'h18AA, 8'h01, 9);
        put(9, 13'h0410, 8'h00, 10);
        put(10, 13'h1430, 8'h00, 48);
        put(48, 13'h1E90 + 13'(b), 8'h00, 49);
        put(49, 13'h1014, 8'h00, 20);
        put(20, {5'h1C, k2}, k2, 50);
        put(50, 13'h1EA0, k2, 13'h1fff);
        put(51, 13'h0020, k2, 32);
        put(32, {5'h1C, k3}, k3, 52);
        put(52, 13'h1EB0, k3, 13'h1fff);
        put(53, 13'h0040, k3, 64);
        // increment-skip, bit set and test, control and enable ops, then a pc write
        put(64, 13'h18FF, 8'hFF, 65);
        put(65, 13'h0051, 8'hFF, 66);
        put(66, 13'h07D1, 8'hFF, 67);
        put(67, 13'h1855, 8'hFF, 68);
        put(68, 13'h0AD1, 8'hFF, 69);
        put(69, 13'h0ED1, 8'hFF, 70);
        put(70, 13'h1800, 8'hFF, 71);
        put(71, 13'h0411, 8'h08, 72);
        put(72, 13'h1850, 8'h50, 73);
        put(73, 13'h0002, 8'h50, 74);
        put(74, 13'h0010, 8'h50, 75);
        put(75, 13'h0042, 8'h50, 80);
        put(80, 13'h0004, 8'h50, 81);
        put(81, 13'h0003, 8'h50, 82);
        @(negedge clock_in);
        arst_n_in = 1'b0;
        opt = mode;
        repeat (12) @(negedge clock_in);
        arst_n_in = 1'b1;
        for (int i = 0; i < e_acc.size(); i++) begin
            gap = 0;
            do begin
                @(negedge clock_in);
                gap++;
            end while (done !== 1'b1 && gap < 20);
            check("acc", 13'(acc), 13'(e_acc[i]));
            if (e_pc[i] != 13'h1fff) begin
                check("pc", addr, e_pc[i]);
            end
            if (i > 0) begin
                check("gap", 13'(gap), mode ? 13'h0004 : 13'h0002);
            end
            check("wdt", 13'(wdt), 13'(i >= e_acc.size() - 2));
            if (i == 11) begin
                check("bank", 13'(bank[1:0]), 13'(b));
            end
            if (i >= e_acc.size() - 2) begin
                check("flags", 13'(st[4:3]), i == e_acc.size() - 2 ? 13'h3 : 13'h2);
            end
        end
        repeat (12) @(negedge clock_in);
        check("halt", addr, 13'd82);
        check("cont", 13'(cont), 13'h0050);
        check("irq", 13'(irq), 13'h0001);
        check("sleep", 13'(sleep), 13'h1);
        $display("run with option %0d finished", mode);
    endtask : run
    // cut a hang short
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        void'($urandom(32'hd34c));
        run(1'b0);
        run(1'b1);
        final_report();
    end
endmodule : tb
bind mid_core mid_core_props mid_core_props_inst (.clock_in(clock_in),
    .arst_n_in(arst_n_in), .rom_addr_out(rom_addr_out), .acc_out(acc_out),
    .status_out(status_out), .sleep_out(sleep_out), .wdt_clear_out(wdt_clear_out),
    .instr_done_out(instr_done_out));
`default_nettype wire
